// ### rtl/stm_pkg.sv
// constants, register map and types of the sixteen-bit timer block
package stm_pkg;

  // ------------------------------------------------------------
  // bus and register map
  // ------------------------------------------------------------
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;

  localparam logic [ADDR_W-1:0] OFS_COUNT_LOW  = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_COUNT_HIGH = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_CONTROL    = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_CMP_LOW    = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_CMP_HIGH   = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_CMP_MODE   = 4'h5;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 4'h6;
  localparam logic [ADDR_W-1:0] OFS_IRQ_CLEAR  = 4'h7;
  localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE = 4'h8;

  // ------------------------------------------------------------
  // counter_control_reg fields
  // ------------------------------------------------------------
  localparam int unsigned CTRL_ON_BIT     = 0;
  localparam int unsigned CTRL_CS_BIT     = 1;
  localparam int unsigned CTRL_SYNCDIS_BIT = 2;
  localparam int unsigned CTRL_OSCEN_BIT  = 3;
  localparam int unsigned CTRL_PS_LSB     = 4;
  localparam int unsigned CTRL_RUN_BIT    = 6;
  localparam logic [7:0]  CTRL_RESET      = 8'h00;
  localparam logic [7:0]  CTRL_WMASK      = 8'h3F;

  // ------------------------------------------------------------
  // compare unit, events, reset values
  // ------------------------------------------------------------
  localparam logic [3:0]  CMP_MODE_SPECIAL = 4'hB;
  localparam logic [3:0]  CMP_MODE_RESET   = 4'h0;
  localparam logic [15:0] CMP_RESET        = 16'h0000;
  localparam logic [15:0] COUNT_CLEARED    = 16'h0000;
  localparam logic [15:0] COUNT_TOP        = 16'hFFFF;
  localparam int unsigned EV_OVF_BIT       = 0;
  localparam int unsigned EV_TRIG_BIT      = 1;
  localparam int unsigned EV_N             = 2;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned PS_W          = 3;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef struct packed {
    logic              wrStb;
    logic              rdStb;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } stm_bus_t;

  typedef struct packed {
    logic [7:0]      ctrl;
    logic [15:0]     cmpVal;
    logic [3:0]      cmpMode;
    logic            adcEnable;
    logic [EV_N-1:0] status;
    logic [EV_N-1:0] irqEn;
    logic [PS_W-1:0] psCnt;
    logic            extPrev;
    logic            armed;
    logic            matchPrev;
    logic [7:0]      rdata;
    logic            irq;
    logic            adcStart;
    logic            oscRun;
  } stm_state_t;

endpackage

// ### rtl/stm_timer.sv
// sixteen-bit timer/counter with compare-driven clear and register port
`timescale 1ns/1ps
`default_nettype none
module stm_timer
  import stm_pkg::*;
(
  // clock and resets
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire logic              otherRst,
  // register port
  input  wire logic              wrStb,
  input  wire logic              rdStb,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  output logic      [DATA_W-1:0] rdata,
  // pins and system
  input  wire logic              extClk,
  input  wire logic              sleepMode,
  input  wire logic              sysClkFromOsc,
  input  wire logic              adcOn,
  // outputs
  output logic                   oscRun,
  output logic                   adcStart,
  output logic                   irq
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  stm_bus_t   bus;
  stm_state_t st_q;
  stm_state_t st_d;
  logic [15:0] count_q;
  logic [15:0] count_d;

  logic            timerOn;
  logic            extMode;
  logic            syncDis;
  logic [1:0]      psSel;
  logic [PS_W-1:0] psMax;
  logic            inEdge;
  logic            tick;
  logic            match;
  logic            trigger;
  logic            wrLow;
  logic            wrHigh;
  logic            wrap;
  logic [EV_N-1:0] evSet;
  logic [EV_N-1:0] evClr;

  assign bus = '{wrStb: wrStb, rdStb: rdStb, addr: addr, wdata: wdata};

  always_comb begin
    timerOn = st_q.ctrl[CTRL_ON_BIT];
    extMode = st_q.ctrl[CTRL_CS_BIT];
    syncDis = st_q.ctrl[CTRL_SYNCDIS_BIT];
    psSel   = st_q.ctrl[CTRL_PS_LSB +: 2];
    psMax   = PS_W'((4'h1 << psSel) - 4'h1);
    wrLow   = bus.wrStb && (bus.addr == OFS_COUNT_LOW);
    wrHigh  = bus.wrStb && (bus.addr == OFS_COUNT_HIGH);
    // input edge: internal clock every cycle outside sleep, external on a rising edge once a falling edge has armed it (in sleep only unsynchronized)
    if (!extMode) begin
      inEdge = timerOn;
    end else begin
      inEdge = timerOn && st_q.armed && extClk && !st_q.extPrev && !(sleepMode && !syncDis);
    end
    if (!extMode && sleepMode) begin
      inEdge = 1'b0;
    end
    tick    = inEdge && (st_q.psCnt == psMax);
    match   = (count_q == st_q.cmpVal);
    trigger = (st_q.cmpMode == CMP_MODE_SPECIAL) && match && !st_q.matchPrev
              && !(extMode && syncDis);
    wrap    = tick && (count_q == COUNT_TOP) && !wrLow && !wrHigh && !trigger;
  end

  // ------------------------------------------------------------
  // count register, kept through every reset
  // ------------------------------------------------------------
  always_comb begin
    count_d = count_q;
    if (wrLow || wrHigh) begin
      if (wrLow) begin
        count_d[7:0] = bus.wdata;
      end
      if (wrHigh) begin
        count_d[15:8] = bus.wdata;
      end
    end else if (trigger) begin
      count_d = COUNT_CLEARED;
    end else if (tick) begin
      count_d = count_q + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys) begin
    count_q <= count_d;
  end

  // ------------------------------------------------------------
  // registers and control
  // ------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    evSet = '0;
    evClr = '0;
    evSet[EV_OVF_BIT]  = wrap;
    evSet[EV_TRIG_BIT] = trigger && !wrLow && !wrHigh;
    // prescaler
    if (wrLow || wrHigh) begin
      st_d.psCnt = '0;
    end else if (inEdge) begin
      st_d.psCnt = tick ? '0 : st_q.psCnt + 3'h1;
    end
    // falling edge arms the external counter
    st_d.extPrev = extClk;
    if (!timerOn || !extMode) begin
      st_d.armed = 1'b0;
    end else if (!extClk && st_q.extPrev) begin
      st_d.armed = 1'b1;
    end
    st_d.matchPrev = match && (st_q.cmpMode == CMP_MODE_SPECIAL);
    // register writes
    if (bus.wrStb) begin
      unique case (bus.addr)
        OFS_CONTROL:    st_d.ctrl = bus.wdata & CTRL_WMASK;
        OFS_CMP_LOW:    st_d.cmpVal[7:0] = bus.wdata;
        OFS_CMP_HIGH:   st_d.cmpVal[15:8] = bus.wdata;
        OFS_CMP_MODE: begin
          st_d.cmpMode   = bus.wdata[3:0];
          st_d.adcEnable = bus.wdata[4];
        end
        OFS_IRQ_CLEAR:  evClr = bus.wdata[EV_N-1:0];
        OFS_IRQ_ENABLE: st_d.irqEn = bus.wdata[EV_N-1:0];
        default: ;
      endcase
    end
    st_d.ctrl[CTRL_RUN_BIT] = sysClkFromOsc;
    // sticky status: set wins over clear
    st_d.status = (st_q.status & ~evClr) | evSet;
    st_d.irq    = |(st_d.status & st_q.irqEn);
    st_d.adcStart = trigger && !wrLow && !wrHigh && st_q.adcEnable && adcOn;
    st_d.oscRun   = st_d.ctrl[CTRL_OSCEN_BIT];
    // read data stand one cycle after the strobe
    st_d.rdata = 8'h00;
    if (bus.rdStb) begin
      unique case (bus.addr)
        OFS_COUNT_LOW:  st_d.rdata = count_q[7:0];
        OFS_COUNT_HIGH: st_d.rdata = count_q[15:8];
        OFS_CONTROL:    st_d.rdata = st_q.ctrl;
        OFS_CMP_LOW:    st_d.rdata = st_q.cmpVal[7:0];
        OFS_CMP_HIGH:   st_d.rdata = st_q.cmpVal[15:8];
        OFS_CMP_MODE:   st_d.rdata = {3'h0, st_q.adcEnable, st_q.cmpMode};
        OFS_IRQ_STATUS: st_d.rdata = {6'h00, st_q.status};
        OFS_IRQ_ENABLE: st_d.rdata = {6'h00, st_q.irqEn};
        default:        st_d.rdata = 8'h00;
      endcase
    end
    // warm reset keeps control and every other register, clears only the read data and adcStart
    if (otherRst) begin
      st_d.rdata    = 8'h00;
      st_d.adcStart = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_q <= '{ctrl: CTRL_RESET, cmpVal: CMP_RESET, cmpMode: CMP_MODE_RESET, adcEnable: 1'b0,
                 status: '0, irqEn: '0, psCnt: '0, extPrev: 1'b0, armed: 1'b0,
                 matchPrev: 1'b0, rdata: 8'h00, irq: 1'b0, adcStart: 1'b0, oscRun: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign rdata    = st_q.rdata;
  assign irq      = st_q.irq;
  assign adcStart = st_q.adcStart;
  assign oscRun   = st_q.oscRun;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_wrap_sets_flag: assert property (
    (tick && count_q == COUNT_TOP && !bus.wrStb && !trigger)
      |=> (count_q == COUNT_CLEARED) && st_q.status[EV_OVF_BIT])
    else $error("wrap did not clear count or set overflow flag");

  a_trig_clears: assert property (
    (trigger && !wrLow && !wrHigh) |=> (count_q == COUNT_CLEARED))
    else $error("special trigger did not clear the count");

  a_trig_noflag: assert property (
    (trigger && !st_q.status[EV_OVF_BIT] && !tick) |=> !st_q.status[EV_OVF_BIT])
    else $error("trigger clear set the overflow flag");

  a_async_noclear: assert property (
    (extMode && syncDis) |-> !trigger)
    else $error("trigger clear acted in unsynchronized mode");

  a_write_wins: assert property (
    (trigger && wrLow && !wrHigh) |=> (count_q[7:0] == $past(bus.wdata)))
    else $error("trigger clear overrode a count write");

  a_write_ps_clear: assert property (
    (wrLow || wrHigh) |=> (st_q.psCnt == '0))
    else $error("count write left the prescaler running");

  a_osc_follows: assert property (
    (bus.wrStb && bus.addr == OFS_CONTROL) |-> ##2 (oscRun == $past(bus.wdata[CTRL_OSCEN_BIT], 2)))
    else $error("oscillator run does not follow enable bit");

  a_read_byte: assert property (
    (bus.rdStb && bus.addr == OFS_COUNT_HIGH) |=> (rdata == $past(count_q[15:8])))
    else $error("high count byte read returned wrong value");

  a_div8_spacing: assert property (
    (tick && psSel == 2'h3 && !extMode && !sleepMode && !bus.wrStb)
      ##1 (!bus.wrStb && !sleepMode && !extMode && timerOn && psSel == 2'h3) [*7] |=> tick)
    else $error("divide-by-8 prescale tick spacing wrong");

  a_sync_sleep: assert property (
    (extMode && !syncDis && sleepMode) |-> !inEdge)
    else $error("synchronized counter advanced in sleep");

  a_ctrl_kept: assert property (
    (otherRst && !bus.wrStb) |=> (st_q.ctrl[5:0] == $past(st_q.ctrl[5:0])))
    else $error("control changed on a warm reset");

  c_wrap:     cover property (wrap);
  c_trigger:  cover property (trigger ##1 adcStart);
  c_collide:  cover property (trigger && wrLow);
  c_irq:      cover property (!irq ##1 irq);

endmodule // stm_timer
`default_nettype wire

// ### tb/stm_pulse_src.sv
// external count source that stands at the timer's count input
`timescale 1ns/1ps
`default_nettype none
module stm_pulse_src (
  // clock
  input  wire logic clk_sys,
  // count input of the timer
  output logic      extClk
);
  initial extClk = 1'b0;
  // each pulse is two cycles high and, within a burst, three low; the line rests low between bursts
  task automatic pulses(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys) extClk <= 1'b1;
      repeat (2) @(posedge clk_sys);
      extClk <= 1'b0;
      repeat (2) @(posedge clk_sys);
    end
  endtask
endmodule // stm_pulse_src
`default_nettype wire

// ### tb/stm_timer_tb.sv
// self-checking testbench of the sixteen-bit timer
`timescale 1ns/1ps
`default_nettype none
module stm_timer_tb;
  import stm_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic clk_sys, rst, otherRst, wrStb, rdStb;
  logic sleepMode, sysClkFromOsc, adcOn;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata, rv;
  logic oscRun, adcStart, irq, extClk;
  logic [15:0] cv;
  int failures = 0, n_checks = 0, adcCnt = 0, n0;
  initial begin
    clk_sys = 1'b0;
    forever #(CLK_PERIOD_NS/2) clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) if (adcStart === 1'b1) adcCnt++;
  stm_pulse_src src_u (.clk_sys(clk_sys), .extClk(extClk));
  stm_timer dut_u (.clk_sys(clk_sys), .rst(rst), .otherRst(otherRst), .wrStb(wrStb), .rdStb(rdStb),
    .addr(addr), .wdata(wdata), .rdata(rdata), .extClk(extClk), .sleepMode(sleepMode),
    .sysClkFromOsc(sysClkFromOsc), .adcOn(adcOn), .oscRun(oscRun), .adcStart(adcStart), .irq(irq));
  // ----------------------------------------
  // bus and check tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys) begin wrStb <= 1; addr <= a; wdata <= d; end
    @(posedge clk_sys) wrStb <= 0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk_sys) begin rdStb <= 1; addr <= a; end
    @(posedge clk_sys) rdStb <= 0;
    @(negedge clk_sys) rv = rdata;
  endtask
  // high, low, high again; only the low byte reread when the high bytes differ
  task automatic rd16();
    logic [7:0] h;
    rd(OFS_COUNT_HIGH); h = rv;
    rd(OFS_COUNT_LOW); cv[7:0] = rv;
    rd(OFS_COUNT_HIGH); cv[15:8] = rv;
    if (rv !== h) begin rd(OFS_COUNT_LOW); cv[7:0] = rv; end
  endtask
  // clear low byte, then high, then low
  task automatic load(input logic [15:0] v);
    wr(OFS_COUNT_LOW, 8'h00); wr(OFS_COUNT_HIGH, v[15:8]); wr(OFS_COUNT_LOW, v[7:0]);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    rd(OFS_CONTROL); chk("ctrl after rst", 16'h00, rv);
    rd(OFS_IRQ_STATUS); chk("status after rst", 16'h00, rv);
    chk("oscRun after rst", 16'h0, oscRun);
    $display("test reset done");
  endtask
  task automatic t_keep();
    wr(OFS_COUNT_LOW, 8'h55); wr(OFS_COUNT_HIGH, 8'hAA); wr(OFS_CONTROL, 8'h38);
    repeat (20) @(posedge clk_sys);
    sleepMode <= 1;
    sysClkFromOsc <= 1;
    @(posedge clk_sys) otherRst <= 1;
    @(posedge clk_sys) otherRst <= 0;
    rd16(); chk("count after warm reset", 16'hAA55, cv);
    rd(OFS_CONTROL); chk("ctrl after warm reset", 16'h78, rv);
    sysClkFromOsc <= 0;
    rd(OFS_CONTROL); chk("ctrl run bit low", 16'h38, rv);
    chk("oscRun in sleep", 16'h1, oscRun);
    wr(OFS_CONTROL, 8'h00); sleepMode <= 0;
    repeat (2) @(posedge clk_sys);
    chk("oscRun off", 16'h0, oscRun);
    $display("test keep done");
  endtask
  task automatic t_prescale();
    for (int c = 0; c < 4; c++) begin
      wr(OFS_CONTROL, 8'(c * 16 + 3)); src_u.pulses(1);
      load(16'h0000); src_u.pulses(8); repeat (4) @(posedge clk_sys);
      rd16(); chk("prescaled count", 16'(8 >> c), cv);
    end
    wr(OFS_CONTROL, 8'h31); load(16'h0000); repeat (80) @(posedge clk_sys);
    wr(OFS_CONTROL, 8'h00);
    rd16(); chk("internal divide by 8", 16'h000A, cv);
    $display("test prescale done");
  endtask
  task automatic t_sleep();
    sleepMode <= 1;
    wr(OFS_CONTROL, 8'h03); src_u.pulses(1); load(16'h0000); src_u.pulses(3);
    rd16(); chk("sync count in sleep", 16'h0000, cv);
    wr(OFS_CONTROL, 8'h07); src_u.pulses(1); load(16'h0000); src_u.pulses(3);
    rd16(); chk("async count in sleep", 16'h0003, cv);
    sleepMode <= 0;
    $display("test sleep done");
  endtask
  task automatic t_ovf();
    wr(OFS_IRQ_ENABLE, 8'h00); wr(OFS_CONTROL, 8'h03); src_u.pulses(1);
    load(COUNT_TOP); src_u.pulses(1); repeat (3) @(posedge clk_sys);
    rd16(); chk("count after wrap", COUNT_CLEARED, cv);
    rd(OFS_IRQ_STATUS); chk("overflow flag", 16'h01, rv);
    chk("irq masked", 16'h0, irq);
    wr(OFS_IRQ_ENABLE, 8'h01); repeat (2) @(posedge clk_sys);
    chk("irq enabled", 16'h1, irq);
    wr(OFS_IRQ_CLEAR, 8'h01); repeat (2) @(posedge clk_sys);
    chk("irq cleared", 16'h0, irq);
    rd(OFS_IRQ_STATUS); chk("status cleared", 16'h00, rv);
    $display("test overflow done");
  endtask
  task automatic t_trig();
    adcOn <= 1;
    wr(OFS_CMP_LOW, 8'h05); wr(OFS_CMP_HIGH, 8'h00); wr(OFS_CMP_MODE, 8'h1B);
    wr(OFS_CONTROL, 8'h03); src_u.pulses(1); load(16'h0000); n0 = adcCnt;
    src_u.pulses(5); repeat (3) @(posedge clk_sys);
    rd16(); chk("count after trigger", COUNT_CLEARED, cv);
    rd(OFS_IRQ_STATUS); chk("trigger status", 16'h02, rv);
    chk("conversion starts", 16'd1, 16'(adcCnt - n0));
    wr(OFS_IRQ_CLEAR, 8'h03);
    wr(OFS_CONTROL, 8'h07); src_u.pulses(1); load(16'h0000);
    src_u.pulses(5); repeat (3) @(posedge clk_sys);
    rd16(); chk("async no clear", 16'h0005, cv);
    rd(OFS_IRQ_STATUS); chk("async no trigger", 16'h00, rv);
    wr(OFS_CONTROL, 8'h00); adcOn <= 0;
    $display("test trigger done");
  endtask
  task automatic t_unmapped();
    wr(4'hF, 8'hA5); rd(4'hF); chk("unmapped read", 16'h00, rv);
    rd(OFS_IRQ_CLEAR); chk("clear reg read", 16'h00, rv);
    $display("test unmapped done");
  endtask
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    otherRst = 1'b0;
    wrStb = 1'b0;
    rdStb = 1'b0;
    sleepMode = 1'b0;
    sysClkFromOsc = 1'b0;
    adcOn = 1'b0;
    addr = '0;
    wdata = '0;
    repeat (8) @(posedge clk_sys);
    rst <= 0;
    t_reset(); t_keep(); t_prescale(); t_sleep(); t_ovf(); t_trig(); t_unmapped();
    summarize();
  end
  initial begin
    #(CLK_PERIOD_NS * 20000);
    failures++;
    summarize();
  end
endmodule // stm_timer_tb
`default_nettype wire
